// ### rtl/sae_pkg.sv
// register map, field layout and mode codes of the serial control-two block
package sae_pkg;
  // byte offsets of the register words
  localparam logic [7:0] OFF_CTRL2 = 8'h00;
  localparam logic [7:0] OFF_CTRL1 = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_MASK = 8'h0c;
  localparam logic [7:0] OFF_TXBUF = 8'h10;
  localparam logic [7:0] OFF_RXBUF = 8'h14;
  // serial_control_two field positions
  localparam int C2_SGNEXT = 15;
  localparam int C2_FRAME_ERROR_EVENT_EN = 12;
  localparam int C2_ROVEN = 11;
  localparam int C2_TUREN = 10;
  localparam int C2_IGNORE_RX_OVERFLOW = 9;
  localparam int C2_IGNORE_TX_UNDERRUN = 8;
  localparam int C2_AUDIO_PROTOCOL_EN = 7;
  localparam int C2_MONO = 3;
  localparam int C2_FMT_LO = 0;
  localparam logic [31:0] C2_WMASK = 32'h0000_9f8b;
  localparam logic [31:0] C2_LOCKED = 32'h0000_008b;
  localparam logic [31:0] C2_RESET = 32'h0000_0000;
  // module enable in control one
  localparam int C1_ON = 0;
  // status layout: raw flags, gated events, engine state
  localparam int ST_FLAG_LO = 0;
  localparam int ST_EVT_LO = 4;
  localparam int ST_HALT = 8;
  localparam int ST_RXFULL = 9;
  localparam int ST_TXFULL = 10;
  localparam int FLAG_FRM = 0;
  localparam int FLAG_ROV = 1;
  localparam int FLAG_TUR = 2;
  // bench link clock figures
  localparam int SYS_PERIOD_NS = 100;
  localparam int LINK_PERIOD_NS = 800;
  localparam int LINK_HALF_CYC = (LINK_PERIOD_NS / 2) / SYS_PERIOD_NS;
  typedef enum logic [1:0] {
    SAE_FMT_I2S = 2'b00,
    SAE_FMT_LJ = 2'b01,
    SAE_FMT_RJ = 2'b10,
    SAE_FMT_PCM = 2'b11
  } sae_fmt_t;
  typedef enum logic [1:0] {
    SAE_IDLE = 2'b00,
    SAE_RUN = 2'b01,
    SAE_HALT = 2'b10
  } sae_state_t;
endpackage

// ### rtl/sae_sync_if.sv
// filtered link pin levels and edge pulses passed from the synchroniser
`timescale 1ns/1ps
interface sae_sync_if #(parameter int W = 3);
  logic [W-1:0] level;
  logic [W-1:0] rise;
  logic [W-1:0] fall;
  modport src (output level, rise, fall);
  modport dst (input level, rise, fall);
endinterface // sae_sync_if

// ### rtl/sae_pin_sync.sv
// three-stage pin synchroniser with agreement filter and edge pulses
`timescale 1ns/1ps
module sae_pin_sync #(
  parameter int W = 3
) (
  input wire logic clk, // system clock
  input wire logic rst, // async reset, active high
  input wire logic [W-1:0] raw, // pins from the link
  sae_sync_if.src o // filtered levels and edges
);
  import sae_pkg::*;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic s1_reg;
      logic s2_reg;
      logic s3_reg;
      logic lvl_reg;
      // the first stage feeds only the second
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          s1_reg <= 1'b0;
          s2_reg <= 1'b0;
          s3_reg <= 1'b0;
        end else begin
          s1_reg <= raw[i];
          s2_reg <= s1_reg;
          s3_reg <= s2_reg;
        end
      end
      // a change counts only once the second and third stages agree
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          lvl_reg <= 1'b0;
        end else if (s2_reg == s3_reg) begin
          lvl_reg <= s3_reg;
        end
      end
      // edge pulses lead the level by one cycle to save link margin
      assign o.level[i] = lvl_reg;
      assign o.rise[i] = (s2_reg == s3_reg) && s3_reg && !lvl_reg;
      assign o.fall[i] = (s2_reg == s3_reg) && !s3_reg && lvl_reg;
    end
  endgenerate
endmodule // sae_pin_sync

// ### rtl/sae_top.sv
// serial control-two block: register port, error events and audio link engine
//
// Strobed register access and the placing of the registers were decided locally.
`timescale 1ns/1ps
module sae_top #(
  parameter int DATA_W = 16, // serial word width
  parameter int SLOT_W = 32 // audio slot width in link clocks
) (
  input wire logic SYS_CLK, // system clock
  input wire logic RESET, // async reset, active high
  input wire logic [7:0] ADDR, // register byte address
  input wire logic [31:0] WR_DATA, // write data
  input wire logic WR_EN, // write strobe
  input wire logic RD_EN, // read strobe
  output logic [31:0] RD_DATA, // read data, cycle after strobe
  output logic IRQ, // level interrupt
  input wire logic LINK_SCK, // bit clock from the partner
  input wire logic LINK_WS, // word select or frame or select
  input wire logic LINK_SDI, // serial data in
  output logic LINK_SDO // serial data out
);
  import sae_pkg::*;

  // refuse widths the counters and sign extension cannot serve
  generate
    if (DATA_W < 8 || DATA_W > 31 || SLOT_W < DATA_W || SLOT_W > 64) begin : g_bad
      $error("sae_top: DATA_W must be 8..31 and SLOT_W DATA_W..64");
    end
  endgenerate

  localparam logic [6:0] WORD_BITS = 7'(DATA_W);
  localparam logic [6:0] RJ_PAD = 7'(SLOT_W - DATA_W);

  // register state
  logic [31:0] ctrl2_reg;
  logic on_reg;
  logic [2:0] flag_reg;
  logic [2:0] evt_reg;
  logic [2:0] mask_reg;
  logic [DATA_W-1:0] tx_hold_reg;
  logic tx_full_reg;
  logic [DATA_W-1:0] rx_hold_reg;
  logic rx_full_reg;
  logic [31:0] rd_data_reg;
  logic irq_reg;
  // engine state
  sae_state_t st_reg;
  logic ws_last_reg;
  logic [6:0] bits_reg;
  logic [6:0] skip_reg;
  logic slot_reg;
  logic [DATA_W-1:0] tx_sh_reg;
  logic [DATA_W-1:0] tx_cur_reg;
  logic [DATA_W-1:0] rx_sh_reg;
  logic sdo_reg;

  // link pins cross into the system clock domain
  sae_sync_if #(.W(3)) lk();
  sae_pin_sync #(.W(3)) u_sync (
    .clk(SYS_CLK),
    .rst(RESET),
    .raw({LINK_WS, LINK_SDI, LINK_SCK}),
    .o(lk.src)
  );

  logic sck_rise;
  logic sck_fall;
  logic sdi;
  logic ws;
  assign sck_rise = lk.rise[0];
  assign sck_fall = lk.fall[0];
  assign sdi = lk.level[1];
  assign ws = lk.level[2];

  // register port decode
  logic wr_c2, wr_c1, wr_st, wr_mask, wr_tx, rd_rx;
  assign wr_c2 = WR_EN && (ADDR == OFF_CTRL2);
  assign wr_c1 = WR_EN && (ADDR == OFF_CTRL1);
  assign wr_st = WR_EN && (ADDR == OFF_STATUS);
  assign wr_mask = WR_EN && (ADDR == OFF_MASK);
  assign wr_tx = WR_EN && (ADDR == OFF_TXBUF);
  assign rd_rx = RD_EN && (ADDR == OFF_RXBUF);

  // control fields; mono and format are masked off outside audio mode
  logic aud_en, mono_eff, pcm_mode, ign_rov, ign_tur;
  sae_fmt_t fmt;
  assign aud_en = ctrl2_reg[C2_AUDIO_PROTOCOL_EN];
  assign fmt = sae_fmt_t'(ctrl2_reg[C2_FMT_LO +: 2]);
  assign mono_eff = aud_en && ctrl2_reg[C2_MONO];
  assign pcm_mode = aud_en && (fmt == SAE_FMT_PCM);
  assign ign_rov = ctrl2_reg[C2_IGNORE_RX_OVERFLOW];
  assign ign_tur = ctrl2_reg[C2_IGNORE_TX_UNDERRUN];

  logic running;
  assign running = (st_reg == SAE_RUN);

  // word boundaries: audio framing watches select at bit-clock falls,
  // plain serial framing uses a low-active select seen on its own edges
  logic boundary, spi_abort;
  always_comb begin
    if (aud_en) begin
      if (pcm_mode) begin
        boundary = sck_fall && ws && !ws_last_reg;
      end else begin
        boundary = sck_fall && (ws != ws_last_reg);
      end
      spi_abort = 1'b0;
    end else begin
      boundary = lk.fall[2];
      spi_abort = lk.rise[2];
    end
  end

  // bits between the boundary and the first data bit, per framing
  logic [6:0] skip_val;
  always_comb begin
    skip_val = 7'h00;
    if (aud_en) begin
      unique case (fmt)
        SAE_FMT_I2S: skip_val = 7'h01;
        SAE_FMT_LJ: skip_val = 7'h00;
        SAE_FMT_RJ: skip_val = RJ_PAD;
        SAE_FMT_PCM: skip_val = 7'h01;
      endcase
    end
  end

  logic in_data, last_bit, word_done, frame_err;
  assign in_data = (skip_reg == 7'h00) && (bits_reg != 7'h00);
  assign last_bit = (bits_reg == 7'h01);
  assign word_done = running && sck_rise && in_data && last_bit;
  // a new boundary or a raised select inside a word is a frame error
  assign frame_err = running && (boundary || spi_abort) && in_data;

  // next transmit word is staged at run start and after every word,
  // so its first bit is already on the pin when the boundary arrives
  logic run_start, preload, next_slot, reuse, underrun;
  logic [DATA_W-1:0] next_word;
  assign run_start = (st_reg == SAE_IDLE) && on_reg;
  assign preload = run_start || word_done;
  assign next_slot = run_start ? 1'b0 : (aud_en && !slot_reg);
  assign reuse = mono_eff && next_slot;
  assign underrun = preload && !reuse && !tx_full_reg;
  always_comb begin
    if (reuse) begin
      next_word = tx_cur_reg;
    end else if (tx_full_reg) begin
      next_word = tx_hold_reg;
    end else begin
      next_word = '0;
    end
  end

  // receive: a full holding word refuses the new one either way
  logic [DATA_W-1:0] rx_word;
  logic rx_full_eff, overflow;
  assign rx_word = {rx_sh_reg[DATA_W-2:0], sdi};
  assign rx_full_eff = rx_full_reg && !rd_rx;
  assign overflow = word_done && rx_full_eff;

  logic critical;
  assign critical = (overflow && !ign_rov) || (underrun && !ign_tur && running);

  // control two; locked fields hold while the module is enabled
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      ctrl2_reg <= C2_RESET;
    end else if (wr_c2) begin
      if (on_reg) begin
        ctrl2_reg <= (WR_DATA & C2_WMASK & ~C2_LOCKED) | (ctrl2_reg & C2_LOCKED);
      end else begin
        ctrl2_reg <= WR_DATA & C2_WMASK;
      end
    end
  end

  // module enable
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      on_reg <= 1'b0;
    end else if (wr_c1) begin
      on_reg <= WR_DATA[C1_ON];
    end
  end

  // engine state; a halt is left only by clearing the module enable
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      st_reg <= SAE_IDLE;
    end else begin
      unique case (st_reg)
        SAE_IDLE: if (on_reg) begin
          st_reg <= SAE_RUN;
        end
        SAE_RUN: if (!on_reg) begin
          st_reg <= SAE_IDLE;
        end else if (critical) begin
          st_reg <= SAE_HALT;
        end
        SAE_HALT: if (!on_reg) begin
          st_reg <= SAE_IDLE;
        end
        default: st_reg <= SAE_IDLE;
      endcase
    end
  end

  // select history, tracked at bit-clock falls in every state
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      ws_last_reg <= 1'b0;
    end else if (sck_fall) begin
      ws_last_reg <= ws;
    end
  end

  // bit and skip counters; pcm runs the second slot straight on
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      bits_reg <= 7'h00;
      skip_reg <= 7'h00;
    end else if (!running) begin
      bits_reg <= 7'h00;
      skip_reg <= 7'h00;
    end else if (boundary) begin
      bits_reg <= WORD_BITS;
      skip_reg <= skip_val;
    end else if (spi_abort) begin
      bits_reg <= 7'h00;
      skip_reg <= 7'h00;
    end else if (sck_fall && skip_reg != 7'h00) begin
      skip_reg <= skip_reg - 7'h01;
    end else if (sck_rise && in_data) begin
      if (last_bit && pcm_mode && !slot_reg) begin
        bits_reg <= WORD_BITS;
      end else begin
        bits_reg <= bits_reg - 7'h01;
      end
    end
  end

  // transmit shifter: shift after each sampled bit, stage on preload
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      tx_sh_reg <= '0;
      tx_cur_reg <= '0;
      slot_reg <= 1'b0;
    end else if (preload) begin
      tx_sh_reg <= next_word;
      tx_cur_reg <= next_word;
      slot_reg <= next_slot;
    end else if (running && sck_rise && in_data) begin
      tx_sh_reg <= {tx_sh_reg[DATA_W-2:0], 1'b0};
    end
  end

  // serial output is quiet outside the run state except in the first cycle of a halt on overflow; it drops as soon as the
  // enable clears, since the state machine only leaves run a cycle later
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      sdo_reg <= 1'b0;
    end else if (preload && on_reg) begin
      sdo_reg <= next_word[DATA_W-1];
    end else if (!running || !on_reg) begin
      sdo_reg <= 1'b0;
    end else if (sck_rise && in_data) begin
      sdo_reg <= tx_sh_reg[DATA_W-2];
    end
  end

  // receive shifter
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      rx_sh_reg <= '0;
    end else if (running && sck_rise && in_data) begin
      rx_sh_reg <= rx_word;
    end
  end

  // receive holding word; overflow keeps the old word, set wins over read
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      rx_hold_reg <= '0;
      rx_full_reg <= 1'b0;
    end else if (word_done && !rx_full_eff) begin
      rx_hold_reg <= rx_word;
      rx_full_reg <= 1'b1;
    end else if (overflow) begin
      rx_full_reg <= 1'b1;
    end else if (rd_rx) begin
      rx_full_reg <= 1'b0;
    end
  end

  // transmit holding word; a write beside a take keeps it full
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      tx_hold_reg <= '0;
      tx_full_reg <= 1'b0;
    end else if (wr_tx) begin
      tx_hold_reg <= WR_DATA[DATA_W-1:0];
      tx_full_reg <= 1'b1;
    end else if (preload && !reuse && on_reg) begin
      tx_full_reg <= 1'b0;
    end
  end

  // raw flags and gated error events, write one to clear, set wins
  logic [2:0] flag_set, evt_set, evt_en;
  assign flag_set = {underrun && running, overflow, frame_err};
  assign evt_en = {ctrl2_reg[C2_TUREN], ctrl2_reg[C2_ROVEN], ctrl2_reg[C2_FRAME_ERROR_EVENT_EN]};
  assign evt_set = flag_set & evt_en;
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      flag_reg <= 3'h0;
      evt_reg <= 3'h0;
    end else begin
      flag_reg <= (flag_reg & ~(wr_st ? WR_DATA[ST_FLAG_LO +: 3] : 3'h0)) | flag_set;
      evt_reg <= (evt_reg & ~(wr_st ? WR_DATA[ST_EVT_LO +: 3] : 3'h0)) | evt_set;
    end
  end

  // interrupt mask and output; irq follows the event bits by one cycle
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      mask_reg <= 3'h0;
      irq_reg <= 1'b0;
    end else begin
      if (wr_mask) begin
        mask_reg <= WR_DATA[ST_EVT_LO +: 3];
      end
      irq_reg <= |(evt_reg & mask_reg);
    end
  end

  // read mux; unmapped and write-only words read zero
  logic [31:0] rd_mux;
  logic [31:0] rx_ext;
  assign rx_ext = ctrl2_reg[C2_SGNEXT] ? {{(32 - DATA_W){rx_hold_reg[DATA_W-1]}}, rx_hold_reg}
                                       : {{(32 - DATA_W){1'b0}}, rx_hold_reg};
  always_comb begin
    unique case (ADDR)
      OFF_CTRL2: rd_mux = ctrl2_reg & C2_WMASK;
      OFF_CTRL1: rd_mux = {31'h0, on_reg};
      OFF_STATUS: rd_mux = {21'h0, tx_full_reg, rx_full_reg, st_reg == SAE_HALT, 1'b0, evt_reg, 1'b0, flag_reg};
      OFF_MASK: rd_mux = {25'h0, mask_reg, 4'h0};
      OFF_RXBUF: rd_mux = rx_ext;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      rd_data_reg <= 32'h0000_0000;
    end else if (RD_EN) begin
      rd_data_reg <= rd_mux;
    end else begin
      rd_data_reg <= 32'h0000_0000;
    end
  end

  assign RD_DATA = rd_data_reg;
  assign IRQ = irq_reg;
  assign LINK_SDO = sdo_reg;
endmodule // sae_top

// ### verif/sae_monitor.sv
// port-level assertions for the serial control-two block
`timescale 1ns/1ps
module sae_monitor #(
  parameter int DATA_W = 16, // serial word width
  parameter int SLOT_W = 32 // audio slot width
) (
  input wire logic SYS_CLK, // system clock
  input wire logic RESET, // async reset, active high
  input wire logic [7:0] ADDR, // register byte address
  input wire logic [31:0] WR_DATA, // write data
  input wire logic WR_EN, // write strobe
  input wire logic RD_EN, // read strobe
  input wire logic [31:0] RD_DATA, // read data
  input wire logic IRQ, // level interrupt
  input wire logic LINK_SCK, // link bit clock
  input wire logic LINK_WS, // link select
  input wire logic LINK_SDI, // link data in
  input wire logic LINK_SDO // link data out
);
  import sae_pkg::*;
  logic on_q; // shadow of the module enable
  logic [31:0] c2_q; // shadow of serial_control_two
  logic mask_nz; // some event is routed to the interrupt
  logic rd_c2;
  logic rd_rx;
  logic rd_st;
  logic rd_none;
  // decoded reads
  assign rd_c2 = RD_EN && ADDR == OFF_CTRL2;
  assign rd_rx = RD_EN && ADDR == OFF_RXBUF;
  assign rd_st = RD_EN && ADDR == OFF_STATUS;
  assign rd_none = RD_EN && (ADDR == OFF_TXBUF || ADDR > OFF_RXBUF || ADDR[1:0] != 2'b00);
  // enable shadow, needed to know which control fields are frozen
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      on_q <= 1'b0;
    end else if (WR_EN && ADDR == OFF_CTRL1) begin
      on_q <= WR_DATA[C1_ON];
    end
  end
  // control-two shadow: frozen fields keep their value while enabled
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      c2_q <= C2_RESET;
    end else if (WR_EN && ADDR == OFF_CTRL2) begin
      c2_q <= on_q ? ((c2_q & C2_LOCKED) | (WR_DATA & C2_WMASK & ~C2_LOCKED)) : (WR_DATA & C2_WMASK);
    end
  end
  // mask shadow
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      mask_nz <= 1'b0;
    end else if (WR_EN && ADDR == OFF_MASK) begin
      mask_nz <= |WR_DATA[6:4];
    end
  end
  default clocking mon_cb @(posedge SYS_CLK);
  endclocking
  default disable iff (RESET);
  chk_idle_read_zero: assert property (!RD_EN |=> RD_DATA == 32'h0000_0000)
    else $error("read data not zero outside a read answer");
  chk_unimpl_bits_zero: assert property (rd_c2 |=> (RD_DATA & ~C2_WMASK) == 32'h0000_0000)
    else $error("unimplemented control bit read as one");
  chk_locked_fields_kept: assert property (rd_c2 |=> (RD_DATA & C2_LOCKED) == (c2_q & C2_LOCKED))
    else $error("audio fields changed while enabled");
  chk_ctrl_value_match: assert property (rd_c2 |=> RD_DATA == $past(c2_q))
    else $error("control register value differs from written history");
  chk_sign_fill_upper: assert property (rd_rx |=>
    RD_DATA[31:DATA_W] == ((c2_q[C2_SGNEXT] && RD_DATA[DATA_W-1]) ? {(32-DATA_W){1'b1}} : {(32-DATA_W){1'b0}}))
    else $error("receive word upper bits wrong for sign setting");
  chk_empty_places_zero: assert property (rd_none |=> RD_DATA == 32'h0000_0000)
    else $error("write-only or unmapped place read non-zero");
  chk_status_spare_zero: assert property (rd_st |=> RD_DATA[31:11] == 21'h0 && !RD_DATA[7] && !RD_DATA[3])
    else $error("spare status bit read as one");
  chk_irq_needs_mask: assert property (IRQ |-> $past(mask_nz))
    else $error("interrupt high with every event masked");
  chk_sdo_quiet_off: assert property (!on_q && !$past(on_q) |-> !LINK_SDO)
    else $error("data out active while disabled");
  // main scenarios reached
  cov_sign_read: cover property (rd_rx ##1 RD_DATA[31]);
  cov_irq_rise: cover property ($rose(IRQ));
  cov_sdo_high: cover property (on_q && LINK_SDO);
endmodule // sae_monitor

// ### verif/sae_link_partner.sv
// behavioural serial partner: clocks frames in, captures the words sent out
`timescale 1ns/1ps
module sae_link_partner #(
  parameter int DATA_W = 16, // word width
  parameter int HALF_NS = 400, // half bit period
  parameter int SLOT_W = 32 // audio slot width in bit clocks
) (
  output logic sck, // bit clock, still between frames
  output logic ws, // select, active low
  output logic sdi, // data toward the block
  input wire logic sdo // data from the block
);
  logic [DATA_W-1:0] cap; // last word seen on sdo
  logic [DATA_W-1:0] cap_r; // last second-slot word seen on sdo
  // idle state: clock low and select released
  initial begin
    sck = 1'b0;
    ws = 1'b1;
    sdi = 1'b0;
    cap = '0;
    cap_r = '0;
  end
  // one frame, msb first; a frame error lifts select halfway and stops the clock
  task automatic send(input logic [DATA_W-1:0] w, input bit ferr);
    #1;
    ws = 1'b0;
    #(HALF_NS);
    for (int i = DATA_W - 1; i >= 0; i--) begin
      sdi = w[i];
      #(HALF_NS);
      cap[i] = sdo; // sampled just before the rise that moves to the next bit
      if (ferr && i == DATA_W / 2) begin
        ws = 1'b1;
        break;
      end
      sck = 1'b1;
      #(HALF_NS);
      sck = 1'b0;
    end
    sdi = ~sdi; // released line must not keep looking valid
    #(HALF_NS);
    ws = 1'b1;
    #(4 * HALF_NS - 1);
  endtask
  // left-justified stereo frame: a lead-in bit, then two slots; select flips
  // while the clock is high so the block sees it settled at the next fall
  task automatic audio(input logic [DATA_W-1:0] l, input logic [DATA_W-1:0] r);
    int j;
    #1;
    for (int k = 0; k <= 2 * SLOT_W; k++) begin
      j = (k + SLOT_W - 1) % SLOT_W;
      sdi = (k > 0 && j < DATA_W) ? (k > SLOT_W ? r[DATA_W-1-j] : l[DATA_W-1-j]) : 1'b0;
      #(HALF_NS);
      if (k > SLOT_W && j < DATA_W) begin
        cap_r[DATA_W-1-j] = sdo;
      end else if (k > 0 && j < DATA_W) begin
        cap[DATA_W-1-j] = sdo;
      end
      sck = 1'b1;
      ws = (k < SLOT_W);
      #(HALF_NS);
      sck = 1'b0;
    end
  endtask
endmodule // sae_link_partner

// ### verif/sae_top_bench.sv
// self-checking bench: register traffic, link frames, queued read checks
`timescale 1ns/1ps
module sae_top_bench;
  import sae_pkg::*;
  typedef struct packed {
    logic [31:0] val;
    logic [31:0] msk;
  } sae_note_t;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wr_data = 32'h0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic rd_q = 1'b0;
  logic [31:0] rd_data;
  logic irq, sck, ws, sdi, sdo;
  logic [15:0] tx, rx;
  int miscompares = 0;
  int cmp_count = 0;
  int cycles = 0;
  sae_note_t notes[$];
  sae_top sae_top_inst (.SYS_CLK(sys_clk), .RESET(reset), .ADDR(addr), .WR_DATA(wr_data), .WR_EN(wr_en),
    .RD_EN(rd_en), .RD_DATA(rd_data), .IRQ(irq), .LINK_SCK(sck), .LINK_WS(ws), .LINK_SDI(sdi), .LINK_SDO(sdo));
  sae_link_partner sae_link_partner_inst (.sck(sck), .ws(ws), .sdi(sdi), .sdo(sdo));
  always #50 sys_clk = ~sys_clk;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // each strobe is assigned once per step, so back-to-back cycles never race
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wr_data <= d;
    wr_en <= w;
    rd_en <= !w;
    @(posedge sys_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hffff_ffff);
    notes.push_back('{e, m});
    bus(1'b0, a, 32'(16'($urandom)));
  endtask
  task automatic idle(input int n);
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic frame(input logic [15:0] w, input bit ferr);
    idle(1);
    sae_link_partner_inst.send(w, ferr);
    @(posedge sys_clk);
  endtask
  task automatic irq_is(input logic e);
    check({31'h0, irq}, {31'h0, e});
  endtask
  // answer watcher: read data stand in the cycle after the strobe
  always @(posedge sys_clk) rd_q <= rd_en;
  always @(negedge sys_clk) begin : watch
    sae_note_t n;
    if (rd_q) begin
      n = notes.pop_front();
      check(rd_data & n.msk, n.val);
    end
  end
  // hang guard, far above the roughly 1500 cycles the sequence needs
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      final_report();
    end
  end
  initial begin
    void'($urandom(32'h5c0d6b18));
    repeat (10) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    rd(OFF_CTRL2, C2_RESET);
    rd(8'h1c, 32'h0);
    rd(OFF_STATUS, 32'h0);
    wr(OFF_CTRL2, 32'hffff_ffff);
    rd(OFF_CTRL2, C2_WMASK);
    // every framing code is accepted while disabled
    for (int f = 0; f < 4; f++) begin
      wr(OFF_CTRL2, 32'h80 | 32'(f));
      rd(OFF_CTRL2, 32'h80 | 32'(f));
    end
    wr(OFF_CTRL1, 32'h1);
    wr(OFF_CTRL2, 32'h0000_9f08);
    rd(OFF_CTRL2, 32'h0000_9f83);
    wr(OFF_CTRL1, 32'h0);
    idle(1);
    wr(OFF_STATUS, 32'h77);
    // tolerated underrun and overflow, plain serial framing
    tx = 16'($urandom);
    rx = 16'($urandom) | 16'h8000;
    wr(OFF_CTRL2, 32'h8b0b);
    wr(OFF_MASK, 32'h70);
    wr(OFF_TXBUF, {16'h0, tx});
    wr(OFF_CTRL1, 32'h1);
    frame(rx, 1'b0);
    check({16'h0, sae_link_partner_inst.cap}, {16'h0, tx});
    rd(OFF_STATUS, 32'h204);
    rd(OFF_RXBUF, {16'hffff, rx});
    rx = 16'($urandom);
    frame(rx, 1'b0);
    check({16'h0, sae_link_partner_inst.cap}, 32'h0);
    frame(~rx, 1'b0);
    irq_is(1'b1);
    wr(OFF_CTRL2, 32'h0b00);
    rd(OFF_STATUS, 32'h226);
    rd(OFF_RXBUF, {16'h0, rx});
    wr(OFF_STATUS, 32'h77);
    idle(3);
    irq_is(1'b0);
    // critical underrun stops the engine
    wr(OFF_CTRL1, 32'h0);
    idle(1);
    wr(OFF_CTRL2, 32'h1400);
    wr(OFF_TXBUF, {16'h0, tx});
    wr(OFF_CTRL1, 32'h1);
    rx = 16'($urandom);
    frame(rx, 1'b0);
    rd(OFF_STATUS, 32'h344);
    irq_is(1'b1);
    // frame error event, then a critical overflow on the unread word
    wr(OFF_CTRL1, 32'h0);
    idle(1);
    wr(OFF_CTRL2, 32'h1900);
    wr(OFF_STATUS, 32'h77);
    wr(OFF_TXBUF, {16'h0, tx});
    wr(OFF_CTRL1, 32'h1);
    frame(rx, 1'b1);
    frame(~rx, 1'b0);
    rd(OFF_STATUS, 32'h133, 32'h133);
    // audio mono, left-justified: both slots carry the one written word
    wr(OFF_CTRL1, 32'h0);
    idle(1);
    rd(OFF_RXBUF, {16'h0, rx});
    wr(OFF_STATUS, 32'h77);
    wr(OFF_CTRL2, 32'h0389);
    wr(OFF_TXBUF, {16'h0, tx});
    wr(OFF_CTRL1, 32'h1);
    rx = 16'($urandom);
    idle(1);
    sae_link_partner_inst.audio(rx, ~rx);
    @(posedge sys_clk);
    check({16'h0, sae_link_partner_inst.cap}, {16'h0, tx});
    check({16'h0, sae_link_partner_inst.cap_r}, {16'h0, tx});
    rd(OFF_STATUS, 32'h206);
    rd(OFF_RXBUF, {16'h0, rx});
    idle(3);
    final_report();
  end
endmodule // sae_top_bench
bind sae_top sae_monitor #(.DATA_W(DATA_W), .SLOT_W(SLOT_W)) sae_monitor_inst (.SYS_CLK(SYS_CLK), .RESET(RESET),
  .ADDR(ADDR), .WR_DATA(WR_DATA), .WR_EN(WR_EN), .RD_EN(RD_EN), .RD_DATA(RD_DATA), .IRQ(IRQ),
  .LINK_SCK(LINK_SCK), .LINK_WS(LINK_WS), .LINK_SDI(LINK_SDI), .LINK_SDO(LINK_SDO));
